/* File: eaos_engine_model.sv */
// engine stand-in: oil pressure from the lube pump, running from cranking
// assumes pump, starter and fuel commands are clk_sys_i levels
`timescale 1ns/1ps

module eaos_engine_model (
	input  wire logic                         clk_sys_i, // clock
	input  wire logic                         rst_n_i,   // reset, low
	input  wire logic                         pump_i,    // lube pump on
	input  wire logic                         starter_i, // starter on
	input  wire logic                         fuel_i,    // fuel open
	input  wire logic                         prompt_i,  // pump builds
	output logic [eaos_pkg::PRES_W-1:0]       meas_o,    // pressure
	output logic                              low_sw_o,  // high: low press
	output logic                              run_o      // engine turning
);
	int pump_cnt;
	int crank_cnt;

	// a weak pump never builds pressure, so the lube cycle must time out
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pump_cnt <= 0;
		else
			pump_cnt <= (pump_i && prompt_i) ? pump_cnt + 1 : 0;
	end
	assign meas_o   = (pump_cnt >= 3) ? 12'h300 : 12'h000;
	assign low_sw_o = (pump_cnt < 3);

	// engine catches after a few starter cycles and stops when fuel closes
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			crank_cnt <= 0;
			run_o     <= 1'b0;
		end else if (!fuel_i) begin
			crank_cnt <= 0;
			run_o     <= 1'b0;
		end else begin
			if (starter_i)
				crank_cnt <= crank_cnt + 1;
			if (crank_cnt >= 3)
				run_o <= 1'b1;
		end
	end
endmodule : eaos_engine_model

/* File: eaos_heater.sv */
// coolant heater thermostat with hysteresis and one-second qualification
// assumes tick_i is a one-cycle pulse every second
`timescale 1ns/1ps

module eaos_heater #(
	parameter int TEMP_W = eaos_pkg::TEMP_W
) (
	input  wire logic              clk_sys_i,  // system clock
	input  wire logic              rst_n_i,    // async reset, low
	input  wire logic              tick_i,     // one-second pulse
	input  wire logic              valid_i,    // temperature available
	input  wire logic [TEMP_W-1:0] temp_i,     // coolant temperature
	input  wire logic [TEMP_W-1:0] low_thr_i,  // switch-on threshold
	input  wire logic [TEMP_W-1:0] high_thr_i, // switch-off threshold
	output logic                   heat_o      // heater command
);

	logic below;
	logic above;
	logic [1:0] below_cnt_reg;
	logic [1:0] above_cnt_reg;

	assign below = valid_i && (temp_i < low_thr_i);
	assign above = valid_i && (temp_i > high_thr_i);

	////////////////////////////////////////////////////////////////////
	// qualification: a full tick interval must pass, so count two ticks
	// (first tick only arms; the second proves at least one second)
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			below_cnt_reg <= 2'h0;
			above_cnt_reg <= 2'h0;
		end else begin
			if (!below)
				below_cnt_reg <= 2'h0;
			else if (tick_i && below_cnt_reg != 2'h2)
				below_cnt_reg <= below_cnt_reg + 2'h1;
			if (!above)
				above_cnt_reg <= 2'h0;
			else if (tick_i && above_cnt_reg != 2'h2)
				above_cnt_reg <= above_cnt_reg + 2'h1;
		end
	end

	// heater state; no measurement forces it off
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			heat_o <= 1'b0;
		else if (!valid_i)
			heat_o <= 1'b0;
		else if (below_cnt_reg == 2'h2)
			heat_o <= 1'b1;
		else if (above_cnt_reg == 2'h2)
			heat_o <= 1'b0;
	end

endmodule : eaos_heater

/* File: eaos_pkg.sv */
// package for the engine auxiliary output sequencer: codes, indices, timing
// assumes a 20 MHz system clock and whole-second duration settings
package eaos_pkg;

	// clock and tick timing
	localparam int CLK_HZ           = 20_000_000;
	localparam int TICK_PERIOD_MS   = 1000;
	localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_PERIOD_MS;
	localparam int RUN_QUAL_MS      = 200;
	localparam int RUN_QUAL_CYCLES  = CLK_HZ / 1000 * RUN_QUAL_MS;
	localparam int HEAT_QUAL_S      = 1;

	// configurable output count and selector width
	localparam int NUM_OUTPUTS      = 16;
	localparam int FUNC_W           = 4;
	localparam int NUM_FLAGS        = 9;

	// output function codes (0 = unassigned / other function)
	localparam logic [3:0] FN_NONE    = 4'h0;
	localparam logic [3:0] FN_GLOW    = 4'h1;
	localparam logic [3:0] FN_CONSENT = 4'h2;
	localparam logic [3:0] FN_FUEL    = 4'h3;
	localparam logic [3:0] FN_GAS     = 4'h4;
	localparam logic [3:0] FN_START   = 4'h5;
	localparam logic [3:0] FN_STOP    = 4'h6;
	localparam logic [3:0] FN_IDLE    = 4'h7;
	localparam logic [3:0] FN_BATTERY_SELECT_FIRST   = 4'h8;
	localparam logic [3:0] FN_BATTERY_SELECT_SECOND   = 4'h9;
	localparam logic [3:0] FN_HEATER  = 4'ha;
	localparam logic [3:0] FN_LUBE    = 4'hb;

	// default assignment, outputs numbered from 1
	localparam int DEF_STOP_OUT  = 4;
	localparam int DEF_START_OUT = 5;
	localparam int DEF_FUEL_OUT  = 6;

	// status flag bit index; flag k is status number 128 + k
	localparam int ST_BASE    = 128;
	localparam int ST_GLOW    = 0;
	localparam int ST_CONSENT = 1;
	localparam int ST_FUEL    = 2;
	localparam int ST_GAS     = 3;
	localparam int ST_START   = 4;
	localparam int ST_STOP    = 5;
	localparam int ST_IDLE    = 6;
	localparam int ST_HEATER  = 7;
	localparam int ST_LUBE    = 8;

	// temperature, pressure and duration widths
	localparam int TEMP_W = 12;
	localparam int PRES_W = 12;
	localparam int DUR_W  = 8;

	// commands arriving from the starting/stopping sequencer
	typedef struct packed {
		logic start_seq;  // starting sequence active, fuel opens
		logic fuel;
		logic consent;
		logic gas;
		logic starter;
		logic stop;
		logic idle;
		logic battery_select_first;
		logic battery_select_second;
	} eaos_cmd_t;

	// oil pressure sensing
	typedef struct packed {
		logic              meas_valid;
		logic [PRES_W-1:0] meas;
		logic [PRES_W-1:0] warn_thr;
		logic [PRES_W-1:0] min_thr;
		logic              low_sw_cfg;
		logic              low_sw;
		logic              alt_sw_cfg;
		logic              alt_sw;
	} eaos_oil_t;

	// pre-start sequencer states, gray along idle->pre->hold
	typedef enum logic [1:0] {
		EAOS_IDLE = 2'b00,
		EAOS_PRE  = 2'b01,
		EAOS_HOLD = 2'b11
	} eaos_state_t;

endpackage : eaos_pkg

/* File: eaos_props.sv */
// assertions on the sequencer top ports, bound into every eaos_top
// assumes one clock domain and levels that settle between edges
`timescale 1ns/1ps

module eaos_props #(
	parameter int TICK_CYC = 20,
	parameter int RUNQ_CYC = 4,
	parameter int NIND     = 5
) (
	input wire logic                           clk_sys_i,       // clock
	input wire logic                           rst_n_i,         // reset
	input wire eaos_pkg::eaos_cmd_t            cmd_i,           // commands
	input wire logic [NIND-1:0]                run_ind_i,       // run signs
	input wire logic [NIND-1:0]                run_ind_en_i,    // enables
	input wire logic                           coolant_valid_i, // temp ok
	input wire logic [eaos_pkg::TEMP_W-1:0]    coolant_temp_i,  // temp
	input wire logic [eaos_pkg::TEMP_W-1:0]    heat_low_thr_i,  // on thr
	input wire logic [eaos_pkg::TEMP_W-1:0]    heat_high_thr_i, // off thr
	input wire logic [eaos_pkg::DUR_W-1:0]     lube_max_s_i,    // lube s
	input wire logic [eaos_pkg::DUR_W-1:0]     glow_max_s_i,    // glow s
	input wire logic [eaos_pkg::NUM_FLAGS-1:0] status_o,        // flags
	input wire logic                           crank_ok_o,      // crank
	input wire logic                           engine_running_o, // running
	input wire logic                           glow_o,          // glow
	input wire logic                           lube_pump_output_o, // lube
	input wire logic                           coolant_heater_output_o // heat
);
	int low_cnt;
	int high_cnt;
	int run_cnt;
	int seq_cnt;

	////////////////////////////////////////////////////////////////////////
	// run lengths of each cause, so durations are judged, not single edges
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			low_cnt  <= 0;
			high_cnt <= 0;
			run_cnt  <= 0;
			seq_cnt  <= 0;
		end else begin
			low_cnt  <= (coolant_valid_i && coolant_temp_i < heat_low_thr_i)
				? low_cnt + 1 : 0;
			high_cnt <= (coolant_valid_i && coolant_temp_i > heat_high_thr_i)
				? high_cnt + 1 : 0;
			run_cnt  <= |(run_ind_i & run_ind_en_i) ? run_cnt + 1 : 0;
			seq_cnt  <= cmd_i.start_seq ? seq_cnt + 1 : 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_heat_valid;
		!coolant_valid_i [*3] |-> !coolant_heater_output_o;
	endproperty
	a_heat_valid: assert property (p_heat_valid)
		else $error("heater on without temperature");
	property p_heat_on;
		$rose(coolant_heater_output_o) |-> low_cnt >= TICK_CYC;
	endproperty
	a_heat_on: assert property (p_heat_on)
		else $error("heater on too early");
	property p_heat_off;
		$fell(coolant_heater_output_o) && coolant_valid_i
			|-> high_cnt >= TICK_CYC;
	endproperty
	a_heat_off: assert property (p_heat_off)
		else $error("heater off too early");
	property p_lube_rise;
		$rose(lube_pump_output_o)
			|-> $past(cmd_i.start_seq, 2) && lube_max_s_i != 8'h00;
	endproperty
	a_lube_rise: assert property (p_lube_rise)
		else $error("lube pump started without start");
	property p_lube_off;
		(lube_max_s_i == 8'h00) [*3] |-> !lube_pump_output_o;
	endproperty
	a_lube_off: assert property (p_lube_off)
		else $error("lube pump on while disabled");
	property p_glow_rise;
		$rose(glow_o) |-> $past(cmd_i.start_seq && cmd_i.fuel, 2)
			&& glow_max_s_i != 8'h00;
	endproperty
	a_glow_rise: assert property (p_glow_rise)
		else $error("glow started without start or enable");
	property p_release;
		engine_running_o [*3] |-> !lube_pump_output_o && !glow_o;
	endproperty
	a_release: assert property (p_release)
		else $error("pre-start outputs held while running");
	property p_crank_wait;
		$rose(crank_ok_o) && glow_max_s_i != 8'h00
			|-> seq_cnt >= (glow_max_s_i - 1) * TICK_CYC;
	endproperty
	a_crank_wait: assert property (p_crank_wait)
		else $error("crank allowed before glow time");
	property p_run_qual;
		$rose(engine_running_o) |-> run_cnt >= RUNQ_CYC;
	endproperty
	a_run_qual: assert property (p_run_qual)
		else $error("running declared too early");
	property p_run_fall;
		!(|(run_ind_i & run_ind_en_i)) |=> !engine_running_o;
	endproperty
	a_run_fall: assert property (p_run_fall)
		else $error("running held without indication");
	property p_consent;
		cmd_i.fuel [*5] |-> status_o[eaos_pkg::ST_CONSENT]
			&& status_o[eaos_pkg::ST_FUEL];
	endproperty
	a_consent: assert property (p_consent)
		else $error("consent or fuel flag missing");

	c_heat: cover property ($rose(coolant_heater_output_o));
	c_crank: cover property ($rose(crank_ok_o));
	c_run: cover property ($rose(engine_running_o));

endmodule : eaos_props

bind eaos_top eaos_props #(.TICK_CYC(TICK_CYC), .RUNQ_CYC(RUNQ_CYC),
	.NIND(NIND)) u_props (.clk_sys_i, .rst_n_i, .cmd_i, .run_ind_i,
	.run_ind_en_i, .coolant_valid_i, .coolant_temp_i, .heat_low_thr_i,
	.heat_high_thr_i, .lube_max_s_i, .glow_max_s_i, .status_o, .crank_ok_o,
	.engine_running_o, .glow_o, .lube_pump_output_o,
	.coolant_heater_output_o);

/* File: eaos_top.sv */
// engine auxiliary output sequencer: pre-start cycles, output mapping
// assumes the starting sequencer supplies commands and run indications
`timescale 1ns/1ps

// Overview of operation
// - each output picks one of eleven engine command function codes
// - consent rises with fuel and may fall later than fuel
// - default mapping: stop on output 4, starter 5, fuel 6
// - each function except the battery selects also appears as status flag 128 to 136
// - mapped outputs are driven even when engine also controlled by CAN
// - heater disabled while no coolant temperature is available
// - heater turns on after one second continuously below low threshold
// - heater turns off after one second continuously above high threshold
// - thermostat runs continuously, also with engine running
// - pre-lubrication enabled only with nonzero maximum lube duration
// - lube pump starts with the starting cycle, as fuel opens
// - lube cycle ends at its maximum time or once pressure established
// - measured pressure compares against warning, else minimum threshold
// - otherwise inactive low switch, preferred over alt switch, means pressure
// - lube pump held after its cycle until engine runs or abort
// - lube held over repeated attempts, timed only on first attempt
// - glow function enabled only with nonzero glow duration
// - glow starts with fuel opening, cycle lasts glow duration seconds
// - glow held after cycle until run or abort, timed first attempt only
// - glow and lube run in parallel, glow extended to longer lube time
// - engine running after an indication persists 0.2 s continuously
module eaos_top #(
	parameter int NOUT        = eaos_pkg::NUM_OUTPUTS,
	parameter int TICK_CYC    = eaos_pkg::TICK_CYCLES,
	parameter int RUNQ_CYC    = eaos_pkg::RUN_QUAL_CYCLES,
	parameter int NIND        = 5
) (
	input  wire logic                          clk_sys_i,        // clock
	input  wire logic                          rst_n_i,          // reset, low
	input  wire eaos_pkg::eaos_cmd_t           cmd_i,            // seq cmds
	input  wire logic [NOUT-1:0][eaos_pkg::FUNC_W-1:0] out_func_i, // maps
	input  wire logic [NIND-1:0]               run_ind_i,        // run signs
	input  wire logic [NIND-1:0]               run_ind_en_i,     // enables
	input  wire logic                          seq_abort_i,      // aborted
	input  wire logic                          coolant_valid_i,  // temp ok
	input  wire logic [eaos_pkg::TEMP_W-1:0]   coolant_temp_i,   // temp
	input  wire logic [eaos_pkg::TEMP_W-1:0]   heat_low_thr_i,   // on thr
	input  wire logic [eaos_pkg::TEMP_W-1:0]   heat_high_thr_i,  // off thr
	input  wire eaos_pkg::eaos_oil_t           oil_i,            // oil sense
	input  wire logic [eaos_pkg::DUR_W-1:0]    lube_max_s_i,     // lube secs
	input  wire logic [eaos_pkg::DUR_W-1:0]    glow_max_s_i,     // glow secs
	output logic [NOUT-1:0]                    dout_o,           // outputs
	output logic [eaos_pkg::NUM_FLAGS-1:0]     status_o,         // st 128+
	output logic                               crank_ok_o,       // may crank
	output logic                               engine_running_o, // running
	output logic                               glow_o,           // glow cmd
	output logic                               lube_pump_output_o, // lube
	output logic                               coolant_heater_output_o // heat
);

	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int RW = $clog2(RUNQ_CYC + 1);
	localparam int DW = eaos_pkg::DUR_W;

	// elaboration checks on parameters
	if (NOUT < eaos_pkg::DEF_FUEL_OUT) begin : g_chk_nout
		$error("eaos_top: too few outputs for the default mapping");
	end
	if (TICK_CYC < 1 || RUNQ_CYC < 1) begin : g_chk_cyc
		$error("eaos_top: cycle counts must be at least one");
	end

	////////////////////////////////////////////////////////////////////
	// one-second tick
	logic [TW-1:0] tick_cnt_reg;
	logic          tick_reg;

	// single time base for every second-based figure
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == TW'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TW'(1);
			tick_reg     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// running-engine qualification
	logic          any_ind;
	logic [RW-1:0] run_cnt_reg;

	assign any_ind = |(run_ind_i & run_ind_en_i);

	// any enabled indication must hold 0.2 s without a break
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_cnt_reg      <= '0;
			engine_running_o <= 1'b0;
		end else if (!any_ind) begin
			run_cnt_reg      <= '0;
			engine_running_o <= 1'b0;
		end else if (run_cnt_reg != RW'(RUNQ_CYC)) begin
			run_cnt_reg      <= run_cnt_reg + RW'(1);
		end else begin
			engine_running_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// oil pressure judgement
	logic press_ok;

	// measured value first, then the switches; a dropped contact means
	// pressure is present
	always_comb begin
		press_ok = 1'b0;
		if (oil_i.meas_valid && oil_i.warn_thr != '0)
			press_ok = oil_i.meas > oil_i.warn_thr;
		else if (oil_i.meas_valid && oil_i.min_thr != '0)
			press_ok = oil_i.meas > oil_i.min_thr;
		else if (oil_i.low_sw_cfg)
			press_ok = !oil_i.low_sw;
		else if (oil_i.alt_sw_cfg)
			press_ok = !oil_i.alt_sw;
	end

	////////////////////////////////////////////////////////////////////
	// pre-start sequencer
	eaos_pkg::eaos_state_t state_reg;
	logic [DW-1:0]         sec_cnt_reg;
	logic                  lube_done_reg;
	logic                  glow_done_reg;
	logic                  first_done_reg;
	logic                  lube_en;
	logic                  glow_en;
	logic [DW-1:0]         glow_len;
	logic                  release_hold;

	assign lube_en      = lube_max_s_i != '0;
	assign glow_en      = glow_max_s_i != '0;
	// glow stretched to the lube time when that is longer
	assign glow_len     = (lube_en && lube_max_s_i > glow_max_s_i) ?
	                      lube_max_s_i : glow_max_s_i;
	assign release_hold = engine_running_o || seq_abort_i ||
	                      !cmd_i.start_seq;

	// state walk; timing only on the first attempt of a sequence
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= eaos_pkg::EAOS_IDLE;
		end else begin
			case (state_reg)
			eaos_pkg::EAOS_IDLE: begin
				if (cmd_i.start_seq && !release_hold)
					state_reg <= eaos_pkg::EAOS_PRE;
			end
			eaos_pkg::EAOS_PRE: begin
				if (release_hold)
					state_reg <= eaos_pkg::EAOS_IDLE;
				else if (lube_done_reg && glow_done_reg)
					state_reg <= eaos_pkg::EAOS_HOLD;
			end
			eaos_pkg::EAOS_HOLD: begin
				if (release_hold)
					state_reg <= eaos_pkg::EAOS_IDLE;
			end
			default: state_reg <= eaos_pkg::EAOS_IDLE;
			endcase
		end
	end

	// seconds counter shared by both cycles, which run in parallel
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			sec_cnt_reg <= '0;
		else if (state_reg != eaos_pkg::EAOS_PRE)
			sec_cnt_reg <= '0;
		else if (tick_reg && sec_cnt_reg != '1)
			sec_cnt_reg <= sec_cnt_reg + DW'(1);
	end

	// cycle end flags; a repeated attempt reuses the first result
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lube_done_reg  <= 1'b0;
			glow_done_reg  <= 1'b0;
			first_done_reg <= 1'b0;
		end else if (state_reg == eaos_pkg::EAOS_IDLE) begin
			lube_done_reg  <= first_done_reg || !lube_en;
			glow_done_reg  <= first_done_reg || !glow_en;
			if (release_hold && !cmd_i.start_seq)
				first_done_reg <= 1'b0;            // sequence over
		end else begin
			if (sec_cnt_reg >= lube_max_s_i || press_ok)
				lube_done_reg <= 1'b1;
			if (sec_cnt_reg >= glow_len)
				glow_done_reg <= 1'b1;
			if (state_reg == eaos_pkg::EAOS_HOLD)
				first_done_reg <= 1'b1;
		end
	end

	// held outputs: lube and glow on from fuel opening until running or abort; crank allowed in hold
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lube_pump_output_o <= 1'b0;
			glow_o             <= 1'b0;
			crank_ok_o         <= 1'b0;
		end else begin
			lube_pump_output_o <= lube_en && cmd_i.fuel &&
			    state_reg != eaos_pkg::EAOS_IDLE;
			glow_o             <= glow_en && cmd_i.fuel &&
			    state_reg != eaos_pkg::EAOS_IDLE;
			crank_ok_o         <=
			    state_reg == eaos_pkg::EAOS_HOLD && !release_hold;
		end
	end

	////////////////////////////////////////////////////////////////////
	// coolant heater
	logic heat_w;

	eaos_heater #(
		.TEMP_W (eaos_pkg::TEMP_W)
	) u_heater (
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.tick_i     (tick_reg),
		.valid_i    (coolant_valid_i),
		.temp_i     (coolant_temp_i),
		.low_thr_i  (heat_low_thr_i),
		.high_thr_i (heat_high_thr_i),
		.heat_o     (heat_w)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			coolant_heater_output_o <= 1'b0;
		else
			coolant_heater_output_o <= heat_w;
	end

	////////////////////////////////////////////////////////////////////
	// status flags and output mapping
	logic [eaos_pkg::NUM_FLAGS-1:0] flags;
	logic                           consent;

	// consent follows fuel up; sequencer may hold it after fuel drops
	assign consent = cmd_i.consent || cmd_i.fuel;

	always_comb begin
		flags = '0;
		flags[eaos_pkg::ST_GLOW]    = glow_o;
		flags[eaos_pkg::ST_CONSENT] = consent;
		flags[eaos_pkg::ST_FUEL]    = cmd_i.fuel;
		flags[eaos_pkg::ST_GAS]     = cmd_i.gas;
		flags[eaos_pkg::ST_START]   = cmd_i.starter && crank_ok_o;
		flags[eaos_pkg::ST_STOP]    = cmd_i.stop;
		flags[eaos_pkg::ST_IDLE]    = cmd_i.idle;
		flags[eaos_pkg::ST_HEATER]  = heat_w;
		flags[eaos_pkg::ST_LUBE]    = lube_pump_output_o;
	end

	// status word, bit k is status 128 + k
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i)
			status_o <= '0;
		else
			status_o <= flags;
	end

	// each output decodes its selector; code 0 leaves the output off.
	// the function selectors come from outside, so default mapping is
	// applied when all selectors read as unassigned
	logic all_none;
	assign all_none = out_func_i == '0;

	for (genvar i = 0; i < NOUT; i++) begin : g_out
		logic [eaos_pkg::FUNC_W-1:0] fsel;
		logic                        val;

		always_comb begin
			fsel = out_func_i[i];
			if (all_none && i == eaos_pkg::DEF_STOP_OUT - 1)
				fsel = eaos_pkg::FN_STOP;
			else if (all_none && i == eaos_pkg::DEF_START_OUT - 1)
				fsel = eaos_pkg::FN_START;
			else if (all_none && i == eaos_pkg::DEF_FUEL_OUT - 1)
				fsel = eaos_pkg::FN_FUEL;
			case (fsel)
			eaos_pkg::FN_GLOW:    val = flags[eaos_pkg::ST_GLOW];
			eaos_pkg::FN_CONSENT: val = flags[eaos_pkg::ST_CONSENT];
			eaos_pkg::FN_FUEL:    val = flags[eaos_pkg::ST_FUEL];
			eaos_pkg::FN_GAS:     val = flags[eaos_pkg::ST_GAS];
			eaos_pkg::FN_START:   val = flags[eaos_pkg::ST_START];
			eaos_pkg::FN_STOP:    val = flags[eaos_pkg::ST_STOP];
			eaos_pkg::FN_IDLE:    val = flags[eaos_pkg::ST_IDLE];
			eaos_pkg::FN_BATTERY_SELECT_FIRST:   val = cmd_i.battery_select_first;
			eaos_pkg::FN_BATTERY_SELECT_SECOND:   val = cmd_i.battery_select_second;
			eaos_pkg::FN_HEATER:  val = flags[eaos_pkg::ST_HEATER];
			eaos_pkg::FN_LUBE:    val = flags[eaos_pkg::ST_LUBE];
			default:              val = 1'b0;
			endcase
		end

		// driven regardless of any CAN control of the engine
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i)
				dout_o[i] <= 1'b0;
			else
				dout_o[i] <= val;
		end
	end

endmodule : eaos_top

/* File: tb_engine_auxiliary_output_sequencer.sv */
// self-checking bench for the sequencer with a short one-second tick
// assumes eaos_props is bound and the engine model sits on the outputs
`timescale 1ns/1ps

module tb_engine_auxiliary_output_sequencer;
	localparam int T = 20;
	logic                clk_sys_i, rst_n_i, abort, cvalid, mv, lcfg, prompt;
	eaos_pkg::eaos_cmd_t cmd;
	logic [15:0][3:0]    func;
	logic [11:0]         temp, meas;
	logic [7:0]          lmax, gmax;
	logic [15:0]         dout;
	logic [8:0]          status;
	logic                crank, running, glow, lube, heat, lsw, run;
	eaos_pkg::eaos_oil_t oil;
	int                  fail_count, n_checks, seed, n, r;

	assign oil = '{meas_valid: mv, meas: meas, warn_thr: 12'h100,
		min_thr: 12'h000, low_sw_cfg: lcfg, low_sw: lsw,
		alt_sw_cfg: 1'b1, alt_sw: 1'b1};

	eaos_top #(.TICK_CYC(T), .RUNQ_CYC(4)) uut (.clk_sys_i, .rst_n_i,
		.cmd_i(cmd), .out_func_i(func), .run_ind_i({4'h0, run}),
		.run_ind_en_i(5'h01), .seq_abort_i(abort), .coolant_valid_i(cvalid),
		.coolant_temp_i(temp), .heat_low_thr_i(12'h064),
		.heat_high_thr_i(12'h0c8), .oil_i(oil), .lube_max_s_i(lmax),
		.glow_max_s_i(gmax), .dout_o(dout), .status_o(status),
		.crank_ok_o(crank), .engine_running_o(running), .glow_o(glow),
		.lube_pump_output_o(lube), .coolant_heater_output_o(heat));

	eaos_engine_model em (.clk_sys_i, .rst_n_i, .pump_i(lube),
		.starter_i(dout[4]), .fuel_i(dout[5]), .prompt_i(prompt),
		.meas_o(meas), .low_sw_o(lsw), .run_o(run));

	////////////////////////////////////////////////////////////////////////
	// free-running clock
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// bounded wait: 0 heater on, 1 crank allowed, 2 running, 3 heater off
	task automatic wait_on(input int sel, input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim && !(sel == 0 ? heat : sel == 1 ? crank :
				sel == 2 ? running : !heat)) begin
			@(posedge clk_sys_i);
			cnt++;
		end
		if (cnt >= lim) begin
			fail_count++;
			$display("wrong value at %0t: wait ran out", $time);
			conclude();
		end
	endtask : wait_on

	// expected output level for one function code and command set
	function automatic logic exp_out(input int c, input eaos_pkg::eaos_cmd_t m);
		case (c)
			2: return m.consent | m.fuel;
			3: return m.fuel;
			4: return m.gas;
			6: return m.stop;
			7: return m.idle;
			8: return m.battery_select_first;
			9: return m.battery_select_second;
			default: return 1'b0;
		endcase
	endfunction : exp_out

	// one start with given durations and oil sensing, up to crank allowed
	task automatic attempt(input int l, input int g, input logic p,
		input logic v, input logic lc, input logic st, input int lo,
		input int hi);
		@(posedge clk_sys_i);
		lmax   <= 8'(l);
		gmax   <= 8'(g);
		prompt <= p;
		mv     <= v;
		lcfg   <= lc;
		cmd    <= '{start_seq: 1'b1, fuel: 1'b1, starter: st, default: 1'b0};
		wait_on(1, 4 * T, n);
		chk(16'(n >= lo && n <= hi), 16'h1);
		chk(16'(lube), 16'(l != 0));
		chk(16'(glow), 16'(g != 0));
		chk(16'(dout[5]), 16'h1);
	endtask : attempt

	// engine catches, pre-start outputs drop, then the start is withdrawn
	task automatic finish_run;
		wait_on(2, 40, n);
		repeat (3) @(posedge clk_sys_i);
		chk(16'({glow, lube}), 16'h0);
		cmd <= '0;
		repeat (6) @(posedge clk_sys_i);
	endtask : finish_run

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 80; rst_n_i = 1'b0; cmd = '0; func = '0; abort = 1'b0;
		cvalid = 1'b0; mv = 1'b0; lcfg = 1'b0; prompt = 1'b0;
		temp = 12'h000; lmax = 8'h00; gmax = 8'h00;
		fail_count = 0; n_checks = 0;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		chk(16'({crank, running, glow, lube, heat}), 16'h0);
		chk(dout, 16'h0000);
		for (int c = 0; c < 16; c++) begin
			r = $random(seed);
			func[0] <= 4'(c);
			cmd <= eaos_pkg::eaos_cmd_t'({1'b0, r[7:0]});
			repeat (4) @(posedge clk_sys_i);
			chk(16'(dout[0]), 16'(exp_out(c, cmd)));
			chk(16'(status[eaos_pkg::ST_FUEL]), 16'(cmd.fuel));
		end
		func <= '0;
		cmd <= '{stop: 1'b1, fuel: 1'b1, default: 1'b0};
		repeat (4) @(posedge clk_sys_i);
		chk(16'(dout[5:3]), 16'h5);
		cmd <= '{consent: 1'b1, default: 1'b0};
		repeat (4) @(posedge clk_sys_i);
		chk(16'({status[1], status[2]}), 16'h2);
		cmd <= '0;
		cvalid <= 1'b1;
		temp <= 12'h032;
		wait_on(0, 3 * T, n);
		chk(16'(n >= T), 16'h1);
		temp <= 12'h096;
		repeat (3 * T) @(posedge clk_sys_i);
		chk(16'({heat, status[7]}), 16'h3);
		temp <= 12'h0fa;
		wait_on(3, 3 * T, n);
		chk(16'(n >= T), 16'h1);
		temp <= 12'h032;
		repeat (T / 2) @(posedge clk_sys_i);
		temp <= 12'h096;
		repeat (2 * T) @(posedge clk_sys_i);
		chk(16'(heat), 16'h0);
		temp <= 12'h032;
		wait_on(0, 3 * T, n);
		cvalid <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		chk(16'(heat), 16'h0);
		attempt(3, 1, 1'b0, 1'b1, 1'b0, 1'b1, 2 * T, 3 * T + 6);
		finish_run();
		attempt(5, 0, 1'b1, 1'b1, 1'b0, 1'b1, 0, T - 1);
		finish_run();
		attempt(5, 0, 1'b1, 1'b0, 1'b1, 1'b1, 0, T - 1);
		finish_run();
		attempt(0, 0, 1'b0, 1'b1, 1'b0, 1'b1, 0, 6);
		finish_run();
		attempt(0, 2, 1'b0, 1'b1, 1'b0, 1'b1, T, 2 * T + 6);
		finish_run();
		attempt(2, 2, 1'b0, 1'b1, 1'b0, 1'b0, T, 2 * T + 6);
		abort <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(16'({glow, lube, crank}), 16'h0);
		abort <= 1'b0;
		wait_on(1, 10, n);
		chk(16'({glow, lube}), 16'h3);
		cmd <= '0;
		repeat (4) @(posedge clk_sys_i);
		conclude();
	end
endmodule : tb_engine_auxiliary_output_sequencer
